// File: lcat_led_model.sv
`timescale 1ns/100ps
module lcat_led_model (
  input wire logic clk_sys, // Clock
  input wire logic [7:0] ledDrive, // LED current
  input wire logic alarmOut, // Alarm pin
  output logic [7:0] ampSqLevel, // Squared level
  output logic [7:0] dcSumLevel, // DC sum level
  output int alarmRises // Alarm rises seen
);
  logic alarmLast = 1'b0;
  initial alarmRises = 0;
  // Light follows current, clipped like a saturated sensor
  assign ampSqLevel = ledDrive > 8'h1f ? 8'hff : {ledDrive[4:0], 3'h0};
  assign dcSumLevel = ledDrive > 8'h3f ? 8'hff : {ledDrive[5:0], 2'h0};
  always @(posedge clk_sys) begin
    if (alarmOut && !alarmLast) alarmRises <= alarmRises + 1;
    alarmLast <= alarmOut;
  end
endmodule // lcat_led_model

// File: lcat_pkg.sv
package lcat_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LVL_W = 8;
  localparam int SETPT_W = 6;
  localparam int INC_W = 3;

  localparam logic [7:0] REG_LOOP_MODE = 8'h01;
  localparam logic [7:0] REG_ILLUM = 8'h06;
  localparam logic [7:0] REG_OUT_TRIM = 8'h07;
  localparam logic [7:0] REG_TEST = 8'h09;
  localparam logic [7:0] REG_INC_CFG = 8'h0b;
  localparam logic [7:0] REG_STATUS = 8'h12;

  localparam int DEADBAND_BIT = 6;
  localparam int LOOP_TYPE_BIT = 6;
  localparam int SETPT_LSB = 0;
  localparam int TRIM_LSB = 2;
  localparam int TA_LSB = 4;
  localparam int TEST_SIGNAL_SELECT_LSB = 0;
  localparam int INC_LSB = 0;
  localparam int ERR_RANGE_BIT = 1;
  localparam int ERR_PARITY_BIT = 2;

  localparam logic RST_DEADBAND = 1'b0;
  localparam logic RST_LOOP_TYPE = 1'b0;
  localparam logic [5:0] RST_SETPT = 6'h00;
  localparam logic [1:0] RST_TRIM = 2'h2;
  localparam logic [1:0] RST_TA = 2'h0;
  localparam logic [3:0] RST_TEST_SIGNAL_SELECT = 4'h0;
  localparam logic [2:0] RST_INC = 3'h0;
  localparam logic [7:0] RST_DRIVE = 8'h00;

  localparam logic [1:0] TA_NORMAL = 2'h0;
  localparam logic [1:0] TA_TEST = 2'h1;
  localparam logic [2:0] INC_DIG_TEST = 3'h5;
  localparam logic [7:0] DRIVE_MAX = 8'hff;
  localparam logic [7:0] DRIVE_MIN = 8'h00;

  localparam int CLK_PERIOD_NS = 8;
  localparam int LOOP_STEP_NS = 10000;
  localparam int LOOP_STEP_CYC =
    (LOOP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOOP_CNT_W = 11;
  localparam logic [10:0] LOOP_CNT_LAST = 11'(LOOP_STEP_CYC - 1);

  typedef enum logic [2:0] {
    LOOP_WAIT = 3'b001,
    LOOP_EVAL = 3'b010,
    LOOP_STEP = 3'b100
  } lcat_loop_state_t;

endpackage

// File: lcat_sync3.sv
`timescale 1ns/100ps
module lcat_sync3 #(
  parameter int W = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset, active high
  input wire logic [W-1:0] async_in, // Level from outside the domain
  output logic [W-1:0] sync_out // Accepted level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // Whole word must agree, so a torn word never passes
          if (s2_q == s3_q) begin
            sync_out[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule // lcat_sync3

// File: lcat_test_route.sv
`timescale 1ns/100ps
module lcat_test_route (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset, active high
  input wire logic [1:0] analogTestSelect, // Analog test field
  input wire logic [3:0] testSignalSelect, // Test signal select
  input wire logic [2:0] incConfig, // Quadrature output config
  input wire logic [2:0] incNormal, // Normal A, B, Z
  input wire logic [47:0] digTestBus, // Pin i uses bits i*16 +: 16
  output logic anaTestEn, // Analog test routing on
  output logic anaFactory, // Factory analog test code
  output logic [3:0] anaMuxSel, // Analog switch select
  output logic [2:0] incOut // Drive for A, B, Z pins
);
  import lcat_pkg::*;

  wire digTest = (incConfig == INC_DIG_TEST);
  wire anaTest = (analogTestSelect == TA_TEST);
  wire anaFac = (analogTestSelect != TA_NORMAL) && !anaTest;
  wire [2:0] incSel;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_pin
      wire [15:0] col = digTestBus[i*16 +: 16];
      assign incSel[i] = digTest ? col[testSignalSelect] : incNormal[i];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      anaTestEn <= 1'b0;
      anaFactory <= 1'b0;
      anaMuxSel <= RST_TEST_SIGNAL_SELECT;
      incOut <= 3'h0;
    end else begin
      anaTestEn <= anaTest;
      anaFactory <= anaFac;
      anaMuxSel <= anaTest ? testSignalSelect : RST_TEST_SIGNAL_SELECT;
      incOut <= incSel;
    end
  end
endmodule // lcat_test_route

// File: lcat_top.sv
`timescale 1ns/100ps
module lcat_top (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic srst, // Sync reset, active high
  input wire logic [7:0] regAddr, // Register address
  input wire logic [7:0] regWrData, // Write data
  input wire logic regWrEn, // Write strobe, one cycle
  input wire logic regRdEn, // Read strobe, one cycle
  output logic [7:0] regRdData, // Read data
  output logic regRdValid, // Read data valid, one cycle
  input wire logic [7:0] ampSqLevel, // Squared amplitude level, async
  input wire logic [7:0] dcSumLevel, // DC sum level, async
  input wire logic ramParityFault, // RAM monitor pulse, same clock
  input wire logic [2:0] incNormal, // Normal A, B, Z
  input wire logic [47:0] digTestBus, // Digital test signals
  output logic [7:0] ledDrive, // LED current source setting
  output logic ledLoopType, // Loop type to analog front end
  output logic alarmOut, // Alarm pin, high on error
  output logic [1:0] oscTrim, // Trim for both oscillators
  output logic anaTestEn, // Analog test routing on
  output logic anaFactory, // Factory analog test code
  output logic [3:0] anaMuxSel, // Analog switch select
  output logic [2:0] incOut // Incremental pin drive
);
  import lcat_pkg::*;

  logic deadband_q;
  logic loopType_q;
  logic [5:0] setpoint_q;
  logic [1:0] trim_q;
  logic [1:0] ta_q;
  logic [3:0] test_signal_select_q;
  logic [2:0] inc_q;
  logic rangeErr_q;
  logic parityErr_q;
  logic alarm_q;
  logic [7:0] drive_q;
  logic upReq_q;
  logic downReq_q;
  logic [10:0] tick_q;
  logic [7:0] rdData_q;
  logic rdValid_q;
  lcat_loop_state_t state_q;
  lcat_loop_state_t state_d;
  logic [7:0] ampSync;
  logic [7:0] dcSync;

  // Both level words share one word-wide agreement check: a word is taken
  // only once two samples match on every bit. A level that never settles
  // delays the update but can never hand over a torn word.
  lcat_sync3 #(.W(16)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .async_in({ampSqLevel, dcSumLevel}),
    .sync_out({ampSync, dcSync})
  );

  // Register decode
  wire wrLoopMode = regWrEn && (regAddr == REG_LOOP_MODE);
  wire wrIllum = regWrEn && (regAddr == REG_ILLUM);
  wire wrOutTrim = regWrEn && (regAddr == REG_OUT_TRIM);
  wire wrTest = regWrEn && (regAddr == REG_TEST);
  wire wrInc = regWrEn && (regAddr == REG_INC_CFG);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      deadband_q <= RST_DEADBAND;
      loopType_q <= RST_LOOP_TYPE;
      setpoint_q <= RST_SETPT;
      trim_q <= RST_TRIM;
      ta_q <= RST_TA;
      test_signal_select_q <= RST_TEST_SIGNAL_SELECT;
      inc_q <= RST_INC;
    end else begin
      if (wrLoopMode) begin
        deadband_q <= regWrData[DEADBAND_BIT];
      end
      if (wrIllum) begin
        loopType_q <= regWrData[LOOP_TYPE_BIT];
        setpoint_q <= regWrData[SETPT_LSB +: SETPT_W];
      end
      if (wrOutTrim) begin
        trim_q <= regWrData[TRIM_LSB +: 2];
      end
      if (wrTest) begin
        ta_q <= regWrData[TA_LSB +: 2];
        test_signal_select_q <= regWrData[TEST_SIGNAL_SELECT_LSB +: 4];
      end
      if (wrInc) begin
        inc_q <= regWrData[INC_LSB +: INC_W];
      end
    end
  end

  // Read mux; unlisted addresses and unused bits read as zero
  wire [7:0] rdLoopMode = {1'b0, deadband_q, 6'h00};
  wire [7:0] rdIllum = {1'b0, loopType_q, setpoint_q};
  wire [7:0] rdOutTrim = {4'h0, trim_q, 2'h0};
  wire [7:0] rdTest = {2'h0, ta_q, test_signal_select_q};
  wire [7:0] rdInc = {5'h00, inc_q};
  wire [7:0] rdStatus = {5'h00, parityErr_q, rangeErr_q, 1'b0};
  wire [7:0] rdMux =
    (regAddr == REG_LOOP_MODE) ? rdLoopMode :
    (regAddr == REG_ILLUM) ? rdIllum :
    (regAddr == REG_OUT_TRIM) ? rdOutTrim :
    (regAddr == REG_TEST) ? rdTest :
    (regAddr == REG_INC_CFG) ? rdInc :
    (regAddr == REG_STATUS) ? rdStatus : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= regRdEn;
      if (regRdEn) begin
        rdData_q <= rdMux;
      end
    end
  end

  // Regulation target: four level codes per setpoint code
  wire [7:0] measured = loopType_q ? dcSync : ampSync;
  wire [7:0] target = {setpoint_q, 2'b00};
  // 1/32 + 1/64 of target, close to five percent
  wire [7:0] band = (target >> 5) + (target >> 6);
  wire [8:0] hiLimit = {1'b0, target} + {1'b0, band};
  wire [7:0] loLimit = target - band;
  wire contUp = measured < target;
  wire contDown = measured > target;
  wire bandUp = measured < loLimit;
  wire bandDown = {1'b0, measured} > hiLimit;
  wire needUp = deadband_q ? bandUp : contUp;
  wire needDown = deadband_q ? bandDown : contDown;
  wire tickDone = (tick_q == LOOP_CNT_LAST);

  always_comb begin
    state_d = state_q;
    case (state_q)
      LOOP_WAIT: begin
        if (tickDone) begin
          state_d = LOOP_EVAL;
        end
      end
      LOOP_EVAL: begin
        state_d = LOOP_STEP;
      end
      LOOP_STEP: begin
        state_d = LOOP_WAIT;
      end
      default: begin
        state_d = LOOP_WAIT;
      end
    endcase
  end

  wire atMax = (drive_q == DRIVE_MAX);
  wire atMin = (drive_q == DRIVE_MIN);
  wire stepNow = (state_q == LOOP_STEP);
  // Range error holds while more current is wanted than is available
  wire rangeErr_d = stepNow ? (upReq_q && atMax) : rangeErr_q;
  // Parity error stays until reset; nothing clears it
  wire parityErr_d = parityErr_q || ramParityFault;
  wire alarm_d = rangeErr_d || parityErr_d;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= LOOP_WAIT;
      tick_q <= 11'h000;
      upReq_q <= 1'b0;
      downReq_q <= 1'b0;
      drive_q <= RST_DRIVE;
    end else begin
      state_q <= state_d;
      tick_q <= (state_q == LOOP_WAIT && !tickDone) ? tick_q + 11'h001 :
        11'h000;
      if (state_q == LOOP_EVAL) begin
        upReq_q <= needUp;
        downReq_q <= needDown;
      end
      if (stepNow && upReq_q && !atMax) begin
        drive_q <= drive_q + 8'h01;
      end else if (stepNow && downReq_q && !atMin) begin
        drive_q <= drive_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rangeErr_q <= 1'b0;
      parityErr_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      rangeErr_q <= rangeErr_d;
      parityErr_q <= parityErr_d;
      alarm_q <= alarm_d;
    end
  end

  lcat_test_route u_route (
    .clk_sys(clk_sys),
    .srst(srst),
    .analogTestSelect(ta_q),
    .testSignalSelect(test_signal_select_q),
    .incConfig(inc_q),
    .incNormal(incNormal),
    .digTestBus(digTestBus),
    .anaTestEn(anaTestEn),
    .anaFactory(anaFactory),
    .anaMuxSel(anaMuxSel),
    .incOut(incOut)
  );

  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign ledDrive = drive_q;
  assign ledLoopType = loopType_q;
  assign alarmOut = alarm_q;
  assign oscTrim = trim_q;
endmodule // lcat_top

// File: lcat_top_asserts.sv
`timescale 1ns/100ps
module lcat_top_asserts (
  input wire logic clk_sys, // Clock
  input wire logic srst, // Reset
  input wire logic [7:0] regAddr, // Address
  input wire logic [7:0] regWrData, // Write data
  input wire logic regWrEn, // Write strobe
  input wire logic regRdEn, // Read strobe
  input wire logic [7:0] regRdData, // Read data
  input wire logic regRdValid, // Read valid
  input wire logic ramParityFault, // RAM fault
  input wire logic [7:0] ledDrive, // LED setting
  input wire logic ledLoopType, // Loop type
  input wire logic alarmOut, // Alarm pin
  input wire logic [1:0] oscTrim, // Trim
  input wire logic anaTestEn, // Test routing
  input wire logic anaFactory, // Factory code
  input wire logic [3:0] anaMuxSel // Switch select
);
  import lcat_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence wr_s(logic [7:0] a);
    regWrEn && regAddr == a;
  endsequence
  sequence st_s;
    regRdValid && $past(regAddr) == REG_STATUS;
  endsequence
  loop_type_a: assert property (wr_s(REG_ILLUM) |=>
    ledLoopType == $past(regWrData[6])) else $error("loop type");
  trim_reset_a: assert property ($fell(srst) |-> oscTrim == RST_TRIM)
    else $error("trim reset");
  trim_write_a: assert property (wr_s(REG_OUT_TRIM) |=>
    oscTrim == $past(regWrData[3:2])) else $error("trim write");
  ana_test_a: assert property (wr_s(REG_TEST) |=> ##1
    anaTestEn == ($past(regWrData[5:4], 2) == TA_TEST) &&
    anaFactory == $past(regWrData[5], 2)) else $error("test field");
  mux_off_a: assert property (!anaTestEn |-> anaMuxSel == 4'h0)
    else $error("mux select");
  led_step_a: assert property ($changed(ledDrive) |->
    ledDrive == 8'($past(ledDrive) + 8'h01) ||
    ledDrive == 8'($past(ledDrive) - 8'h01)) else $error("led step");
  led_hold_a: assert property ($changed(ledDrive) |=>
    $stable(ledDrive) [*8]) else $error("led hold");
  alarm_parity_a: assert property (ramParityFault |=>
    alarmOut ##1 alarmOut) else $error("alarm parity");
  status_alarm_a: assert property (st_s |->
    (regRdData[2:1] != 2'h0) == $past(alarmOut) &&
    regRdData[7:3] == 5'h0 && !regRdData[0]) else $error("status");
  rd_valid_a: assert property (regRdEn |=> regRdValid ##1
    regRdValid == $past(regRdEn)) else $error("read valid");
  range_alarm_a: assert property ($rose(alarmOut) |->
    $past(ramParityFault) || ledDrive == DRIVE_MAX)
    else $error("alarm cause");
endmodule // lcat_top_asserts
bind lcat_top lcat_top_asserts u_chk (.*);

// File: led_control_alarm_test_tb.sv
`timescale 1ns/100ps
module led_control_alarm_test_tb;
  import lcat_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic ramParityFault = 1'b0;
  logic [2:0] incNormal = 3'h0;
  logic [47:0] digTestBus = 48'h0;
  logic [7:0] regRdData, ampSqLevel, dcSumLevel, ledDrive;
  logic regRdValid, ledLoopType, alarmOut, anaTestEn, anaFactory;
  logic [1:0] oscTrim;
  logic [3:0] anaMuxSel;
  logic [2:0] incOut, expInc;
  int num_errors = 0;
  int comparisons = 0;
  int alarmRises, d;
  int seed = 32'h745ea4e3;
  logic [7:0] adr [7] = '{8'h01, 8'h06, 8'h07, 8'h09, 8'h0b, 8'h12, 8'h33};
  logic [7:0] msk [7] = '{8'h40, 8'h7f, 8'h0c, 8'h3f, 8'h07, 8'h00, 8'h00};
  logic [7:0] shd [7];
  lcat_top u_dut (.*);
  lcat_led_model u_led (.*);
  initial forever #4 clk_sys = ~clk_sys;
  initial begin
    #600000;
    num_errors++;
    results();
  end
  task automatic check(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = v;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    check({7'h0, regRdValid}, 8'h01, "valid");
    check(regRdData, exp, "read");
  endtask
  task automatic reset_dut();
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (8) @(negedge clk_sys);
    srst = 1'b0;
  endtask
  // Integer loop model, one call step per loop period
  function automatic int led_model(int d, int typ, int db, int sp, int n);
    int m, t, b;
    t = sp * 4;
    b = db ? (t >> 5) + (t >> 6) : 0;
    repeat (n) begin
      m = typ ? (d > 63 ? 255 : d * 4) : (d > 31 ? 255 : d * 8);
      if (m < t - b && d < 255) d++;
      else if (m > t + b && d > 0) d--;
    end
    return d;
  endfunction
  task automatic results();
    $display("Counts: %0d compares, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    reset_dut();
    for (int i = 0; i < 7; i++) rd(adr[i], i == 2 ? 8'h08 : 8'h00);
    check({6'h0, oscTrim}, 8'h02, "trim reset");
    repeat (20) begin
      for (int i = 0; i < 7; i++) begin
        shd[i] = 8'($random(seed));
        wr(adr[i], shd[i]);
      end
      for (int i = 0; i < 7; i++) rd(adr[i], shd[i] & msk[i]);
      check({6'h0, oscTrim}, {6'h0, shd[2][3:2]}, "trim");
      check({7'h0, ledLoopType}, {7'h0, shd[1][6]}, "type");
    end
    $display("test registers done");
    for (int s = 0; s < 64; s++) begin
      incNormal = 3'($random(seed));
      digTestBus = 48'({$random(seed), $random(seed)});
      wr(REG_TEST, 8'(s));
      wr(REG_INC_CFG, {5'h0, s[1] ? INC_DIG_TEST : 3'h0});
      @(negedge clk_sys);
      for (int p = 0; p < 3; p++)
        expInc[p] = s[1] ? digTestBus[p * 16 + s[3:0]] : incNormal[p];
      check({5'h0, incOut}, {5'h0, expInc}, "inc pins");
      check({6'h0, anaTestEn, anaFactory},
        {6'h0, s[5:4] == 2'h1, s[5]}, "ana mode");
      check({4'h0, anaMuxSel}, s[5:4] == 2'h1 ? 8'(s[3:0]) : 8'h00,
        "ana mux");
    end
    $display("test routing done");
    reset_dut();
    wr(REG_ILLUM, 8'h20);
    repeat (20 * 1252) @(negedge clk_sys);
    d = led_model(0, 0, 0, 32, 20);
    check(ledDrive, 8'(d), "square loop");
    wr(REG_LOOP_MODE, 8'h40);
    wr(REG_ILLUM, 8'h60);
    repeat (20 * 1252) @(negedge clk_sys);
    d = led_model(d, 1, 1, 32, 20);
    check(ledDrive, 8'(d), "sum deadband");
    check({7'h0, alarmOut}, 8'h00, "no alarm");
    rd(REG_STATUS, 8'h00);
    $display("test led loop done");
    ramParityFault = 1'b1;
    @(negedge clk_sys);
    ramParityFault = 1'b0;
    check({7'h0, alarmOut}, 8'h01, "alarm");
    rd(REG_STATUS, 8'h04);
    check(8'(alarmRises), 8'h01, "monitor");
    reset_dut();
    check({7'h0, alarmOut}, 8'h00, "alarm reset");
    $display("test alarm done");
    results();
  end
endmodule // led_control_alarm_test_tb
